// [rtl/ffpipe_core.sv]
module ffpipe_core #(
   parameter int unsigned PC_WIDTH = ffpipe_pkg::PC_WIDTH_DEFAULT,
   parameter int unsigned INST_WIDTH = ffpipe_pkg::INST_WIDTH_DEFAULT,
   parameter int unsigned STARTUP_CYCLES = ffpipe_pkg::STARTUP_WAIT_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Program memory
   output logic [PC_WIDTH-1:0] fetch_addr,
   output logic fetch_strobe,
   input wire logic [INST_WIDTH-1:0] fetch_data,
   // Execute unit
   output logic [INST_WIDTH-1:0] exec_inst,
   output logic exec_valid,
   output logic exec_start,
   output logic [1:0] exec_phase,
   input wire logic exec_branch,
   input wire logic [PC_WIDTH-1:0] exec_target,
   input wire logic halt_req,
   // Power state
   input wire logic wake_pin,
   output logic halted,
   // Oscillator option
   input wire logic rc_osc_sel,
   output logic oscillator_output_pin,
   output logic phase_one_clock,
   output logic decode_execute_phases
);
   // Refuse widths the logic cannot serve: the address port is at most 16 bits
   // and the start-up counter needs at least one clock
   if (PC_WIDTH < 1 || PC_WIDTH > 16) begin : g_pc_width_chk
      $error("PC_WIDTH out of range");
   end
   if (INST_WIDTH < 1) begin : g_inst_width_chk
      $error("INST_WIDTH out of range");
   end
   if (STARTUP_CYCLES < 1) begin : g_startup_chk
      $error("STARTUP_CYCLES out of range");
   end

   // Counter wide enough for the full start-up wait
   localparam int unsigned CW = $clog2(STARTUP_CYCLES + 1);

   typedef enum logic [1:0] {
      ST_RUN,
      ST_HALT,
      ST_WAIT
   } ffpipe_run_type;

   ffpipe_pkg::ffpipe_phase_type phase;
   logic last_phase;
   logic run_r;
   ffpipe_run_type state_r;
   logic [CW-1:0] wait_cnt_r;
   logic [PC_WIDTH-1:0] pc_r;
   logic [INST_WIDTH-1:0] prefetch_r;
   logic prefetch_valid_r;
   logic [INST_WIDTH-1:0] exec_inst_r;
   logic exec_valid_r;
   logic halted_r;
   logic take_branch;
   logic [2:0] wake_sync_r;
   logic wake_seen;
   logic fetch_strobe_r;
   logic [PC_WIDTH-1:0] fetch_addr_r;
   logic osc_r;
   logic t1_r;
   logic dx_r;
   logic start_r;
   logic [1:0] phase_out_r;

   ffpipe_phase_gen u_phase (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .run(run_r),
      .phase(phase),
      .last_phase(last_phase)
   );

   // Phase test shared by the registered views; a frozen generator counts as no phase
   function automatic logic phase_is(
      input logic running,
      input ffpipe_pkg::ffpipe_phase_type now,
      input ffpipe_pkg::ffpipe_phase_type want
   );
      return running && (now == want);
   endfunction : phase_is

   // Branch taken at the end of a valid execute cycle
   assign take_branch = run_r && last_phase && exec_valid_r && exec_branch;

   // Wake pin crosses in from outside: change counted when stages two and three agree
   // A wake pulse sampled at only one clock edge never shows in both stages and is ignored
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wake_sync_r <= 3'h0;
      end else begin
         wake_sync_r <= {wake_sync_r[1:0], wake_pin};
      end
   end
   assign wake_seen = wake_sync_r[1] & wake_sync_r[2];

   // Halt and start-up wait
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_r <= ST_RUN;
         run_r <= 1'b1;
         wait_cnt_r <= '0;
      end else begin
         unique case (state_r)
            // Halt lands only at a cycle end so the phases restart at one
            ST_RUN: begin
               if (halt_req && exec_valid_r && last_phase) begin
                  state_r <= ST_HALT;
                  run_r <= 1'b0;
               end
            end
            // Phases stay frozen at one; nothing is fetched until the wake settles
            ST_HALT: begin
               if (wake_seen) begin
                  state_r <= ST_WAIT;
                  wait_cnt_r <= CW'(STARTUP_CYCLES - 1);
               end
            end
            // Loaded with one less so execution resumes after exactly STARTUP_CYCLES clocks
            ST_WAIT: begin
               if (wait_cnt_r == '0) begin
                  state_r <= ST_RUN;
                  run_r <= 1'b1;
               end else begin
                  wait_cnt_r <= wait_cnt_r - CW'(1);
               end
            end
            // An unused code falls back to running
            default: begin
               state_r <= ST_RUN;
               run_r <= 1'b1;
            end
         endcase
      end
   end

   // Fetch in phase one; prefetched word is promoted at cycle end
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         pc_r <= PC_WIDTH'(ffpipe_pkg::PC_RESET_VALUE);
         prefetch_r <= '0;
         prefetch_valid_r <= 1'b0;
         exec_inst_r <= '0;
         exec_valid_r <= 1'b0;
      end else if (run_r) begin
         // Increment and fetch share phase one so the word matches the address just left
         if (phase == ffpipe_pkg::PH_ONE) begin
            prefetch_r <= fetch_data;
            prefetch_valid_r <= 1'b1;
            pc_r <= pc_r + PC_WIDTH'(1);
         end
         if (take_branch) begin
            // The target is known at this cycle end, so the next cycle is the single dummy
            // one: its phase one fetches the target while the sequential prefetch is dropped
            // The dropped prefetch needs no clearing: the dummy phase one overwrites it
            pc_r <= exec_target;
            exec_valid_r <= 1'b0;
         end else if (last_phase) begin
            // Promotion at the cycle end keeps exec_inst standing for a whole cycle
            exec_inst_r <= prefetch_r;
            exec_valid_r <= prefetch_valid_r;
         end
      end
   end

   // Registered views of the phase and fetch for outputs
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         fetch_strobe_r <= 1'b0;
         fetch_addr_r <= '0;
         t1_r <= 1'b0;
         dx_r <= 1'b0;
         osc_r <= 1'b0;
         start_r <= 1'b0;
         phase_out_r <= 2'h0;
         halted_r <= 1'b0;
      end else begin
         fetch_strobe_r <= phase_is(run_r, phase, ffpipe_pkg::PH_ONE);
         // Memory must already see the target in the phase one after a taken branch
         fetch_addr_r <= take_branch ? exec_target : pc_r;
         t1_r <= phase_is(run_r, phase, ffpipe_pkg::PH_ONE);
         dx_r <= run_r && phase != ffpipe_pkg::PH_ONE;
         // Pin stays low when the crystal option is chosen
         osc_r <= rc_osc_sel && phase_is(run_r, phase, ffpipe_pkg::PH_ONE);
         start_r <= exec_valid_r && phase_is(run_r, phase, ffpipe_pkg::PH_TWO);
         phase_out_r <= phase;
         // Lags run by one clock like the other registered views
         halted_r <= ~run_r;
      end
   end

   // Registered outputs other than exec_inst and exec_valid lag internal phase by one clock
   assign fetch_addr = fetch_addr_r;
   assign fetch_strobe = fetch_strobe_r;
   assign exec_inst = exec_inst_r;
   assign exec_valid = exec_valid_r;
   assign exec_start = start_r;
   assign exec_phase = phase_out_r;
   assign halted = halted_r;
   assign oscillator_output_pin = osc_r;
   assign phase_one_clock = t1_r;
   assign decode_execute_phases = dx_r;
endmodule : ffpipe_core

// [rtl/ffpipe_phase_gen.sv]
// Four-phase generator; advances only while run is high
module ffpipe_phase_gen (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Control
   input wire logic run,
   // Phase state
   output ffpipe_pkg::ffpipe_phase_type phase,
   output logic last_phase
);
   ffpipe_pkg::ffpipe_phase_type phase_r;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         phase_r <= ffpipe_pkg::PH_ONE;
      end else if (!run) begin
         phase_r <= ffpipe_pkg::PH_ONE;
      end else begin
         unique case (phase_r)
            ffpipe_pkg::PH_ONE: phase_r <= ffpipe_pkg::PH_TWO;
            ffpipe_pkg::PH_TWO: phase_r <= ffpipe_pkg::PH_THREE;
            ffpipe_pkg::PH_THREE: phase_r <= ffpipe_pkg::PH_FOUR;
            ffpipe_pkg::PH_FOUR: phase_r <= ffpipe_pkg::PH_ONE;
         endcase
      end
   end

   assign phase = phase_r;
   assign last_phase = (phase_r == ffpipe_pkg::PH_FOUR);
endmodule : ffpipe_phase_gen

// [rtl/ffpipe_pkg.sv]
package ffpipe_pkg;
   // Phase sequence within one instruction cycle
   typedef enum logic [1:0] {
      PH_ONE,
      PH_TWO,
      PH_THREE,
      PH_FOUR
   } ffpipe_phase_type;

   localparam int unsigned PHASES_PER_CYCLE = 4;
   localparam int unsigned STARTUP_WAIT_TSYS = 1024;
   localparam int unsigned STARTUP_WAIT_CYCLES = STARTUP_WAIT_TSYS;
   localparam int unsigned PC_WIDTH_DEFAULT = 12;
   localparam int unsigned INST_WIDTH_DEFAULT = 15;
   localparam logic [11:0] PC_RESET_VALUE = 12'h000;
   localparam int unsigned SYNC_STAGES = 3;
endpackage : ffpipe_pkg

// [verification/ffpipe_core_asserts.sv]
module ffpipe_core_asserts #(
   parameter int unsigned INST_WIDTH = 15
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Observed outputs and option
   input wire logic fetch_strobe,
   input wire logic [INST_WIDTH-1:0] exec_inst,
   input wire logic exec_valid,
   input wire logic exec_start,
   input wire logic [1:0] exec_phase,
   input wire logic halted,
   input wire logic rc_osc_sel,
   input wire logic oscillator_output_pin,
   input wire logic phase_one_clock,
   input wire logic decode_execute_phases
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   phase_wrap_a: assert property (exec_phase == 2'h3 |=> exec_phase == 2'h0) else $error("phase four not followed by one");
   phase_run_a: assert property (exec_phase == 2'h1 |=> exec_phase == 2'h2 ##1 exec_phase == 2'h3)
      else $error("phases two to four out of order");
   phase_excl_a: assert property ($past(nrst, 2) && !halted |-> phase_one_clock != decode_execute_phases)
      else $error("phase flags overlap or gap");
   strobe_gap_a: assert property (fetch_strobe |=> !fetch_strobe [*3]) else $error("fetch closer than four clocks");
   start_phase_a: assert property (exec_start |-> exec_valid && exec_phase == 2'h1)
      else $error("execute start outside phase two");
   inst_hold_a: assert property (exec_start |-> $stable(exec_inst) ##1 $stable(exec_inst))
      else $error("instruction changed mid cycle");
   osc_off_a: assert property (!rc_osc_sel |-> !oscillator_output_pin) else $error("oscillator pin driven when off");
   osc_phase_a: assert property (rc_osc_sel && $past(rc_osc_sel) |-> oscillator_output_pin == phase_one_clock)
      else $error("oscillator pin differs from phase one");
   reset_first_a: assert property ($rose(nrst) |-> !exec_valid [*4]) else $error("execution before first fetch");
endmodule : ffpipe_core_asserts
bind ffpipe_core ffpipe_core_asserts #(.INST_WIDTH(INST_WIDTH)) chk (.sys_clk(sys_clk), .nrst(nrst),
   .fetch_strobe(fetch_strobe), .exec_inst(exec_inst), .exec_valid(exec_valid), .exec_start(exec_start),
   .exec_phase(exec_phase), .halted(halted), .rc_osc_sel(rc_osc_sel), .oscillator_output_pin(oscillator_output_pin),
   .phase_one_clock(phase_one_clock), .decode_execute_phases(decode_execute_phases));

// [verification/ffpipe_prog_mem.sv]
// Asynchronous store; each word carries its own address so fetch order shows
module ffpipe_prog_mem (
   // Fetch side
   input wire logic [11:0] fetch_addr,
   output logic [14:0] fetch_data
);
   timeunit 1ns;
   timeprecision 1ps;
   assign fetch_data = {3'h5, fetch_addr};
endmodule : ffpipe_prog_mem

// [verification/tb_ffpipe_core.sv]
module tb_ffpipe_core;
   timeunit 1ns;
   timeprecision 1ps;
   // Short start-up wait keeps the run brief
   localparam int unsigned SC = 8;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic exec_branch = 1'b0;
   logic halt_req = 1'b0;
   logic wake_pin = 1'b0;
   logic rc_osc_sel = 1'b0;
   logic [11:0] exec_target = 12'h000;
   logic [11:0] fetch_addr;
   logic [14:0] fetch_data;
   logic [14:0] exec_inst;
   logic [1:0] exec_phase;
   logic fetch_strobe, exec_valid, exec_start, halted, osc_pin, p1, dep;
   int mismatches = 0;
   int cmp_count = 0;
   always #20 sys_clk = ~sys_clk;
   ffpipe_core #(.STARTUP_CYCLES(SC)) uut (.sys_clk(sys_clk), .nrst(nrst), .fetch_addr(fetch_addr),
      .fetch_strobe(fetch_strobe), .fetch_data(fetch_data), .exec_inst(exec_inst), .exec_valid(exec_valid),
      .exec_start(exec_start), .exec_phase(exec_phase), .exec_branch(exec_branch), .exec_target(exec_target),
      .halt_req(halt_req), .wake_pin(wake_pin), .halted(halted), .rc_osc_sel(rc_osc_sel),
      .oscillator_output_pin(osc_pin), .phase_one_clock(p1), .decode_execute_phases(dep));
   ffpipe_prog_mem mem (.fetch_addr(fetch_addr), .fetch_data(fetch_data));
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude
   task automatic cmp_word(input logic [14:0] got, input logic [14:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask : cmp_word
   task automatic cmp_cnt(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask : cmp_cnt
   // Samples just after the edge so registered outputs have settled
   task automatic wait_until(ref logic s, input logic v, output int n);
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (s !== v && n < 60);
      if (s !== v) begin
         mismatches++;
         $display("[FAIL] %0t wait limit reached", $time);
         conclude();
      end
   endtask : wait_until
   task automatic t_seq();
      int n;
      for (int i = 0; i < 3; i++) begin
         wait_until(exec_start, 1'b1, n);
         cmp_word(exec_inst, {3'h5, 12'(i)});
         if (i > 0) cmp_cnt(n, 4, 4);
      end
   endtask : t_seq
   task automatic t_osc();
      int c;
      c = 0;
      @(posedge sys_clk);
      rc_osc_sel <= 1'b1;
      repeat (3) @(posedge sys_clk);
      repeat (8) begin
         @(posedge sys_clk);
         #1;
         c += int'(osc_pin);
      end
      cmp_cnt(c, 2, 2);
   endtask : t_osc
   // Branch is raised in phase four and held for three clocks so the cycle end sees it
   task automatic t_branch();
      int n;
      wait_until(exec_start, 1'b1, n);
      @(posedge sys_clk);
      exec_branch <= 1'b1;
      exec_target <= 12'h0A5;
      repeat (3) @(posedge sys_clk);
      exec_branch <= 1'b0;
      wait_until(exec_start, 1'b1, n);
      cmp_word(exec_inst, 15'h50A5);
      cmp_cnt(n, 4, 4);
   endtask : t_branch
   task automatic t_halt();
      int n;
      int s;
      s = 0;
      @(posedge sys_clk);
      halt_req <= 1'b1;
      wait_until(halted, 1'b1, n);
      @(posedge sys_clk);
      halt_req <= 1'b0;
      repeat (12) begin
         @(posedge sys_clk);
         #1;
         s += int'(fetch_strobe);
      end
      cmp_cnt(s, 0, 0);
      @(posedge sys_clk);
      wake_pin <= 1'b1;
      wait_until(halted, 1'b0, n);
      cmp_cnt(n, SC, SC + 8);
      @(posedge sys_clk);
      wake_pin <= 1'b0;
   endtask : t_halt
   initial begin
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      t_seq();
      t_osc();
      t_branch();
      t_halt();
      conclude();
   end
endmodule : tb_ffpipe_core
